// [hw/etcp_pkg.sv]
package etcp_pkg;
	localparam int BYTE_W = 8;
	localparam int STAT_W = 32;
	localparam int CTRL_W = 5;
	// Register byte offsets, low four address bits
	localparam logic [3:0] ADR_CTRL = 4'h0;
	localparam logic [3:0] ADR_STATS = 4'h4;
	localparam logic [3:0] ADR_FRAMES = 4'h8;
	// Control register fields
	localparam int CTL_SPD_LO = 0;
	localparam int CTL_SPD_HI = 1;
	localparam int CTL_HALF = 2;
	localparam int CTL_MEDIA = 3;
	localparam int CTL_GAPADJ = 4;
	localparam logic [4:0] CTRL_RESET = 5'h02;
	// Line rate codes
	localparam logic [1:0] SPD_10 = 2'h0;
	localparam logic [1:0] SPD_100 = 2'h1;
	localparam logic [1:0] SPD_1000 = 2'h2;
	// Clock cycles per byte minus one, for each line rate
	localparam logic [6:0] PACE_10 = 7'h63;
	localparam logic [6:0] PACE_100 = 7'h09;
	localparam logic [6:0] PACE_1000 = 7'h00;
	// Statistics vector fields
	localparam int ST_OK = 0;
	localparam int ST_BCAST = 1;
	localparam int ST_MCAST = 2;
	localparam int ST_UNDERRUN = 3;
	localparam int ST_LEN_LO = 5;
	localparam int ST_LEN_HI = 18;
	localparam int ST_EXCESS = 23;
	localparam int ST_ATT_LO = 25;
	localparam int ST_ATT_HI = 28;
	localparam logic [13:0] LEN_MAX = 14'h3ff0;
	localparam logic [3:0] ATT_LAST = 4'hf;
	// Gap in byte times, and destination address handling
	localparam logic [7:0] MIN_GAP = 8'h0c;
	localparam logic [2:0] DA_BYTES = 3'h6;
	localparam logic [7:0] BYTE_ALL = 8'hff;
	typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_GAP} etcp_state_t;
endpackage

// [hw/etcp_tx_client_port.sv]
// Functional notes
// - Client error during a frame makes the device signal error to PHY.
// - Ready is high in the cycle the offered valid byte is accepted.
// - At 10 and 100 Mb/s ready meters bytes to the line rate.
// - Half duplex: collision output pulses when the medium collides during a frame.
// - Collision and retransmit stay zero in full duplex.
// - A 32-bit statistics vector describes the last frame sent.
// - Statistics valid pulses when a frame's transmission ends.
// - Optional second stream behaves like the main one.
// - At 100 Mb/s the second stream's ready meters its bytes.
// - All stream and sideband signals are active high.
// - Length field counts bytes, saturating at 16368.
// - Excessive flag set after collisions on sixteen attempts.
// - Bit zero set when the last frame went without error.
module etcp_tx_client_port #(
	parameter int ADR_W = 8
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [etcp_pkg::BYTE_W-1:0] tx_byte,
	input wire logic tx_byte_valid,
	input wire logic tx_frame_end,
	input wire logic tx_frame_error,
	output logic tx_accept,
	input wire logic [etcp_pkg::BYTE_W-1:0] media_tx_byte,
	input wire logic media_tx_byte_valid,
	input wire logic media_tx_frame_end,
	input wire logic media_tx_frame_error,
	output logic media_tx_accept,
	input wire logic [7:0] tx_gap_delay,
	output logic tx_collision,
	output logic tx_retransmit,
	output logic [etcp_pkg::STAT_W-1:0] tx_stats,
	output logic tx_stats_valid,
	output logic [etcp_pkg::BYTE_W-1:0] phy_txd,
	output logic phy_tx_en,
	output logic phy_tx_er,
	input wire logic phy_col
);
	import etcp_pkg::*;

	generate
		if (ADR_W < 4) begin : g_chk
			$error("ADR_W must be at least 4");
		end
	endgenerate

	etcp_state_t state, next_state;
	logic [CTRL_W-1:0] ctrl;
	logic [31:0] frames;
	logic [6:0] pace_cnt;
	logic [7:0] gap_cnt;
	logic [13:0] len;
	logic [3:0] attempts;
	logic [2:0] pos;
	logic sel_av, err_seen, bcast, mcast;

	// Control fields
	logic [1:0] speed;
	logic half, media_on, gap_adj;
	assign speed = ctrl[CTL_SPD_HI:CTL_SPD_LO];
	assign half = ctrl[CTL_HALF];
	assign media_on = ctrl[CTL_MEDIA];
	assign gap_adj = ctrl[CTL_GAPADJ];

	// Byte pacing: one byte slot per pace_max+1 cycles
	logic [6:0] pace_max, next_pace;
	logic tick, next_tick;
	assign pace_max = (speed == SPD_10) ? PACE_10 :
		(speed == SPD_100) ? PACE_100 : PACE_1000;
	assign tick = pace_cnt >= pace_max;
	assign next_pace = tick ? 7'h00 : pace_cnt + 7'h01;
	assign next_tick = next_pace >= pace_max;

	// Selected stream
	logic [BYTE_W-1:0] cur_byte;
	logic cur_valid, cur_last, cur_err, cur_rdy;
	assign cur_byte = sel_av ? media_tx_byte : tx_byte;
	assign cur_valid = sel_av ? media_tx_byte_valid : tx_byte_valid;
	assign cur_last = sel_av ? media_tx_frame_end : tx_frame_end;
	assign cur_err = sel_av ? media_tx_frame_error : tx_frame_error;
	assign cur_rdy = sel_av ? media_tx_accept : tx_accept;

	logic in_send, acc, col_evt, give_up, frame_end;
	logic start, start_av, next_sel_av;
	assign in_send = state == ST_SEND;
	assign acc = in_send && cur_valid && cur_rdy;
	assign col_evt = in_send && half && phy_col;
	assign give_up = col_evt && attempts == ATT_LAST;
	assign frame_end = (acc && cur_last && !col_evt) || give_up;
	// The second stream takes precedence when both wait
	assign start_av = media_on && media_tx_byte_valid;
	assign start = state == ST_IDLE && (start_av || tx_byte_valid);
	assign next_sel_av = start ? start_av : sel_av;

	logic [7:0] gap_len;
	assign gap_len = (gap_adj && tx_gap_delay > MIN_GAP) ?
		tx_gap_delay : MIN_GAP;

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (start)
					next_state = ST_SEND;
			end
			ST_SEND: begin
				if (frame_end || col_evt)
					next_state = ST_GAP;
			end
			ST_GAP: begin
				if (tick && gap_cnt <= 8'h01)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// Ready lands only on a pacing slot of the selected stream
	logic next_rdy;
	assign next_rdy = next_state == ST_SEND && next_tick;

	// Frame trackers including the byte accepted this cycle
	logic [13:0] next_len;
	logic next_err, next_bc, next_mc;
	assign next_len = (acc && len != LEN_MAX) ? len + 14'h0001 : len;
	assign next_err = err_seen || (acc && cur_err);
	assign next_bc = (acc && pos < DA_BYTES) ?
		(bcast && cur_byte == BYTE_ALL) : bcast;
	assign next_mc = (acc && pos == 3'h0) ? cur_byte[0] : mcast;

	logic [STAT_W-1:0] vec;
	always_comb begin
		vec = '0;
		vec[ST_OK] = !next_err && !give_up;
		vec[ST_BCAST] = next_bc && pos != 3'h0;
		vec[ST_MCAST] = next_mc;
		vec[ST_UNDERRUN] = next_err;
		vec[ST_LEN_HI:ST_LEN_LO] = next_len;
		vec[ST_EXCESS] = give_up;
		vec[ST_ATT_HI:ST_ATT_LO] = attempts;
	end

	// Wishbone slave: ack one cycle after the request, write on ack
	logic wb_req, wb_hit_ctrl, wb_wr;
	logic [3:0] adr_lo;
	logic [31:0] rd_data;
	assign wb_req = wb_cyc_i && wb_stb_i;
	assign adr_lo = wb_adr_i[3:0];
	assign wb_hit_ctrl = adr_lo == ADR_CTRL;
	assign wb_wr = wb_req && wb_we_i && wb_ack_o && wb_hit_ctrl;
	assign rd_data = (adr_lo == ADR_CTRL) ? {27'h0, ctrl} :
		(adr_lo == ADR_STATS) ? tx_stats :
		(adr_lo == ADR_FRAMES) ? frames : 32'h0;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= CTRL_RESET;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else if (ce) begin
			wb_ack_o <= wb_req && !wb_ack_o;
			wb_dat_o <= rd_data;
			if (wb_wr && wb_sel_i[0])
				ctrl <= wb_dat_i[CTRL_W-1:0];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE;
			sel_av <= 1'b0;
			pace_cnt <= 7'h00;
			gap_cnt <= 8'h00;
			tx_accept <= 1'b0;
			media_tx_accept <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			sel_av <= next_sel_av;
			pace_cnt <= next_pace;
			tx_accept <= next_rdy && !next_sel_av;
			media_tx_accept <= next_rdy && next_sel_av;
			if (next_state == ST_GAP && state != ST_GAP)
				gap_cnt <= gap_len;
			else if (state == ST_GAP && tick)
				gap_cnt <= gap_cnt - 8'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			len <= 14'h0;
			pos <= 3'h0;
			err_seen <= 1'b0;
			bcast <= 1'b1;
			mcast <= 1'b0;
		end else if (ce) begin
			if (start) begin
				len <= 14'h0;
				pos <= 3'h0;
				err_seen <= 1'b0;
				bcast <= 1'b1;
				mcast <= 1'b0;
			end else begin
				len <= next_len;
				err_seen <= next_err;
				bcast <= next_bc;
				mcast <= next_mc;
				if (acc && pos < DA_BYTES)
					pos <= pos + 3'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			attempts <= 4'h0;
			frames <= 32'h0;
			tx_collision <= 1'b0;
			tx_retransmit <= 1'b0;
			tx_stats <= '0;
			tx_stats_valid <= 1'b0;
		end else if (ce) begin
			tx_collision <= col_evt;
			tx_retransmit <= col_evt && !give_up;
			tx_stats_valid <= frame_end;
			if (frame_end) begin
				tx_stats <= vec;
				frames <= frames + 32'h1;
				attempts <= 4'h0;
			end else if (col_evt) begin
				attempts <= attempts + 4'h1;
			end
		end
	end

	// Byte strobe toward the PHY, one per accepted byte
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			phy_txd <= 8'h00;
			phy_tx_en <= 1'b0;
			phy_tx_er <= 1'b0;
		end else if (ce) begin
			phy_tx_en <= acc;
			phy_tx_er <= acc && cur_err;
			if (acc)
				phy_txd <= cur_byte;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	property p_fd_quiet;
		!half && !$past(half) |-> !tx_collision && !tx_retransmit;
	endproperty
	a_fd_quiet: assert property (p_fd_quiet)
		else $error("collision output in full duplex");

	property p_col_cause;
		$past(ce) && tx_collision |->
			$past(phy_col) && $past(half) && $past(in_send);
	endproperty
	a_col_cause: assert property (p_col_cause)
		else $error("collision without cause");

	property p_stat_cause;
		$past(ce) && tx_stats_valid |-> $past(frame_end);
	endproperty
	a_stat_cause: assert property (p_stat_cause)
		else $error("stats valid without frame end");

	property p_len_sat;
		tx_stats[ST_LEN_HI:ST_LEN_LO] <= LEN_MAX;
	endproperty
	a_len_sat: assert property (p_len_sat)
		else $error("length beyond saturation");

	property p_ok_clean;
		tx_stats_valid && tx_stats[ST_OK] |->
			!tx_stats[ST_UNDERRUN] && !tx_stats[ST_EXCESS];
	endproperty
	a_ok_clean: assert property (p_ok_clean)
		else $error("ok flag on a failed frame");

	property p_excess_att;
		tx_stats_valid && tx_stats[ST_EXCESS] |->
			tx_stats[ST_ATT_HI:ST_ATT_LO] == ATT_LAST;
	endproperty
	a_excess_att: assert property (p_excess_att)
		else $error("excessive flag with wrong attempts");

	property p_data_path;
		$past(ce) && $past(acc) |-> phy_tx_en &&
			phy_txd == $past(cur_byte) && phy_tx_er == $past(cur_err);
	endproperty
	a_data_path: assert property (p_data_path)
		else $error("accepted byte not forwarded");

	property p_pace_100;
		$past(ce) && $past(speed) == SPD_100 && $past(tx_accept) |->
			!tx_accept;
	endproperty
	a_pace_100: assert property (p_pace_100)
		else $error("main ready not metered");

	property p_av_pace;
		$past(ce) && $past(speed) == SPD_100 && $past(media_tx_accept)
			|-> !media_tx_accept;
	endproperty
	a_av_pace: assert property (p_av_pace)
		else $error("second stream ready not metered");

	property p_one_stream;
		!(tx_accept && media_tx_accept);
	endproperty
	a_one_stream: assert property (p_one_stream)
		else $error("both streams ready");

	property p_rdy_send;
		tx_accept || media_tx_accept |-> in_send;
	endproperty
	a_rdy_send: assert property (p_rdy_send)
		else $error("ready outside a frame");

	c_frame_ok: cover property (tx_stats_valid && tx_stats[ST_OK]);
	c_retx: cover property (tx_collision && tx_retransmit);
	c_excess: cover property (tx_stats_valid && tx_stats[ST_EXCESS]);
	c_av_frame: cover property (media_tx_accept && media_tx_frame_end &&
		media_tx_byte_valid);
endmodule // etcp_tx_client_port

// [sim/etcp_client_model.sv]
module etcp_client_model (
	input wire logic ref_clk,
	input wire logic accept,
	input wire logic collision,
	output logic [7:0] data,
	output logic valid,
	output logic last,
	output logic err
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		data = 8'h00;
		valid = 1'b0;
		last = 1'b0;
		err = 1'b0;
	end
	// Byte and qualifiers stand until taken; a collision abandons the frame
	task automatic send(input int len, input logic [7:0] b0,
		input logic [7:0] step, input logic bad);
		int i;
		int n;
		i = 0;
		n = 0;
		@(posedge ref_clk);
		while (i < len && n < 3000) begin
			valid <= 1'b1;
			data <= b0 + step * i[7:0];
			last <= (i == len - 1);
			err <= bad;
			@(posedge ref_clk);
			n++;
			if (collision === 1'b1)
				n = 3000;
			else if (accept === 1'b1)
				i++;
		end
		valid <= 1'b0;
		last <= 1'b0;
		err <= 1'b0;
		data <= ~data;
	endtask
endmodule // etcp_client_model

// [sim/etcp_tx_client_port_tb_top.sv]
module etcp_tx_client_port_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import etcp_pkg::*;
	logic ref_clk = 1'b0, nrst = 1'b0, ce = 1'b1, phy_col = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00, gap = 8'h0c, m_b, a_b, txd;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, stats, s, q, f;
	logic m_v, m_l, m_e, m_acc, a_v, a_l, a_e, a_acc;
	logic ack, col, rt, st_v, en, er;
	logic [6:0] pace [3] = '{PACE_10, PACE_100, PACE_1000};
	int n_fail = 0, checks_done = 0, col_n, rt_n, en_n, er_n;
	time t0, t1, t2;
	always #12.5 ref_clk = ~ref_clk;
	etcp_tx_client_port etcp_tx_client_port_inst (
		.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tx_byte(m_b),
		.tx_byte_valid(m_v), .tx_frame_end(m_l), .tx_frame_error(m_e),
		.tx_accept(m_acc), .media_tx_byte(a_b), .media_tx_byte_valid(a_v),
		.media_tx_frame_end(a_l), .media_tx_frame_error(a_e),
		.media_tx_accept(a_acc), .tx_gap_delay(gap), .tx_collision(col),
		.tx_retransmit(rt), .tx_stats(stats), .tx_stats_valid(st_v),
		.phy_txd(txd), .phy_tx_en(en), .phy_tx_er(er), .phy_col(phy_col));
	etcp_client_model etcp_client_model_inst (.ref_clk(ref_clk),
		.accept(m_acc), .collision(col), .data(m_b), .valid(m_v),
		.last(m_l), .err(m_e));
	etcp_client_model etcp_client_model_inst2 (.ref_clk(ref_clk),
		.accept(a_acc), .collision(col), .data(a_b), .valid(a_v),
		.last(a_l), .err(a_e));
	always @(posedge ref_clk) begin
		if (en === 1'b1) begin
			if (en_n == 0)
				t0 = $time;
			t1 = $time;
			en_n++;
			if (er === 1'b1)
				er_n++;
		end
		if (col === 1'b1)
			col_n++;
		if (rt === 1'b1 && col === 1'b1)
			rt_n++;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {4'h0, a};
		wdat <= d;
		sel <= 4'hf;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 50) begin
			n_fail++;
			report_and_stop();
		end
	endtask
	task automatic wait_st;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (st_v !== 1'b1 && n < 3000);
		s = stats;
		@(posedge ref_clk);
		if (n >= 3000) begin
			n_fail++;
			report_and_stop();
		end
	endtask
	// Medium collision while the first byte is out on the wire
	task automatic hit;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (en !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			n_fail++;
			report_and_stop();
		end
		phy_col <= 1'b1;
		@(posedge ref_clk);
		phy_col <= 1'b0;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		wb(1'b0, ADR_CTRL, 32'h0);
		chk("ctrl reset", q, {27'h0, CTRL_RESET});
		wb(1'b1, ADR_STATS, 32'hffffffff);
		wb(1'b0, ADR_STATS, 32'h0);
		chk("stats read only", q, 32'h0);
		wb(1'b0, 4'hc, 32'h0);
		chk("unmapped", q, 32'h0);
		// Clock enable low must hold off the bus answer
		ce <= 1'b0;
		fork
			wb(1'b0, ADR_CTRL, 32'h0);
			begin
				repeat (4) @(posedge ref_clk);
				chk("ce freeze", {31'h0, ack}, 32'h0);
				ce <= 1'b1;
			end
		join
		chk("ce resume", q, {27'h0, CTRL_RESET});
		$display("test registers done");
		phy_col <= 1'b1;
		col_n = 0;
		en_n = 0;
		etcp_client_model_inst.send(6, 8'hff, 8'h00, 1'b0);
		wait_st();
		phy_col <= 1'b0;
		chk("bcast stats", s, 32'h000000c7);
		chk("fd collision", 32'(col_n), 32'h0);
		chk("bytes out", 32'(en_n), 32'h6);
		er_n = 0;
		etcp_client_model_inst.send(4, 8'h10, 8'h01, 1'b1);
		wait_st();
		chk("err stats", s, 32'h00000088);
		chk("phy error", 32'(er_n), 32'h4);
		chk("phy byte", {24'h0, txd}, 32'h13);
		$display("test full duplex frames done");
		for (int k = 0; k < 3; k++) begin
			wb(1'b1, ADR_CTRL, 32'(k));
			en_n = 0;
			etcp_client_model_inst.send(3, 8'h20, 8'h01, 1'b0);
			wait_st();
			chk("pace", 32'((t1 - t0) / 25), 2 * (32'(pace[k]) + 1));
			chk("speed stats", s, 32'h00000061);
		end
		$display("test line rates done");
		wb(1'b1, ADR_CTRL, 32'h0a);
		wb(1'b0, ADR_FRAMES, 32'h0);
		f = q;
		etcp_client_model_inst2.send(4, 8'h01, 8'h01, 1'b0);
		wait_st();
		chk("av stats", s, 32'h00000085);
		wb(1'b0, ADR_STATS, 32'h0);
		chk("stats reg", q, 32'h00000085);
		wb(1'b0, ADR_FRAMES, 32'h0);
		chk("frames", q, f + 1);
		$display("test second stream done");
		// Gap adjust at 1G: 32 gap slots, one idle cycle, one accept cycle
		wb(1'b1, ADR_CTRL, 32'h12);
		gap <= 8'h20;
		etcp_client_model_inst.send(2, 8'h40, 8'h01, 1'b0);
		wait_st();
		t2 = t1;
		en_n = 0;
		etcp_client_model_inst.send(2, 8'h40, 8'h01, 1'b0);
		wait_st();
		chk("gap", 32'((t0 - t2) / 25), 32'h22);
		chk("gap stats", s, 32'h00000041);
		$display("test frame gap done");
		wb(1'b1, ADR_CTRL, 32'h06);
		col_n = 0;
		rt_n = 0;
		fork
			for (int k = 0; k < 16; k++) begin
				fork
					etcp_client_model_inst.send(8, 8'h30, 8'h01, 1'b0);
					hit();
				join
			end
			wait_st();
		join
		chk("excess", s & 32'h1e800001, 32'h1e800000);
		chk("collisions", 32'(col_n), 32'h10);
		chk("retransmits", 32'(rt_n), 32'hf);
		$display("test half duplex done");
		nrst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		wb(1'b0, ADR_FRAMES, 32'h0);
		chk("reset frames", q, 32'h0);
		chk("reset stats", stats, 32'h0);
		wb(1'b0, ADR_CTRL, 32'h0);
		chk("reset ctrl", q, {27'h0, CTRL_RESET});
		$display("test reset done");
		report_and_stop();
	end
endmodule // etcp_tx_client_port_tb_top
